// ### rtl/crx_rx_handler.sv
/*
 Receive object store with acceptance filtering, FIFO chaining, read
 transfers with flag clearing, remote frame requests and bit timing.
 Assumes the protocol core delivers frames on clk_sys and pulses rem_sent
 only while rem_req_r is high; the bus pin is asynchronous.
*/
// Summary of operation
// - Stored standard frames zero identifier bits 17..0
// - Receive interrupt enable sets pending on store
// - Store length code and all eight bytes
// - Use-mask applies identifier, extended, direction masks
// - Read transfer copies identifier, extended flag, length, data and status flags to buffer
// - Clearing affects store only, buffer sees old
// - Message lost flag never cleared by hardware
// - Receive transmit request sends remote frame
// - Matching data frame cancels pending remote request
// - FIFO fills lowest free member first
// - Member with new data skipped unless last
// - Last member overwritten when others locked
// - Bit rates from 1 to 1000 kbit/s
// - Bit is sync plus segment one plus two
// - Quantum is ext times 0x40 plus low plus one
// - Resync moves sample point by at most jump width
`timescale 1ns/1ps
module crx_rx_handler import crx_pkg::*; (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic reset,
   // Object configuration write
   input wire logic cfg_wr,
   input wire logic [OBJ_W-1:0] cfg_obj,
   input wire logic [ID_W-1:0] cfg_identifier_bits,
   input wire logic [ID_W-1:0] cfg_id_mask_bits,
   input wire logic [DLC_W-1:0] cfg_length_code,
   input wire logic cfg_extended_id_flag,
   input wire logic cfg_extended_flag_mask,
   input wire logic cfg_direction_bit,
   input wire logic cfg_direction_mask,
   input wire logic cfg_use_acceptance_mask,
   input wire logic cfg_object_valid_flag,
   input wire logic cfg_end_of_block_flag,
   input wire logic cfg_rx_irq_enable,
   input wire logic cfg_new_data_flag,
   input wire logic cfg_message_lost_flag,
   input wire logic cfg_irq_pending_flag,
   input wire logic cfg_tx_request_flag,
   // Read transfer into the interface buffer
   input wire logic rd_req,
   input wire logic [OBJ_W-1:0] rd_obj,
   input wire logic clear_new_data_select,
   input wire logic clear_irq_pending_select,
   output logic buf_valid_r,
   output logic [OBJ_W-1:0] buf_obj_r,
   output logic [ID_W-1:0] buf_identifier_bits_r,
   output logic buf_extended_id_flag_r,
   output logic [DLC_W-1:0] buf_length_code_r,
   output logic [DATA_W-1:0] buf_data_r,
   output logic buf_new_data_flag_r,
   output logic buf_message_lost_flag_r,
   output logic buf_irq_pending_flag_r,
   output logic buf_tx_request_flag_r,
   // Received frame from the protocol core
   input wire logic rx_frame_stb,
   input wire logic [ID_W-1:0] rx_identifier,
   input wire logic rx_extended,
   input wire logic rx_remote,
   input wire logic [DLC_W-1:0] rx_length_code,
   input wire logic [DATA_W-1:0] rx_data,
   output logic rx_store_r,
   output logic [OBJ_W-1:0] rx_store_obj_r,
   output logic [NUM_OBJ-1:0] irq_pending_flag_r,
   // Remote frame request to the protocol core
   input wire logic rem_sent,
   output logic rem_req_r,
   output logic [ID_W-1:0] rem_identifier_r,
   output logic rem_extended_r,
   // Bit timing
   input wire logic can_rx_pin,
   input wire logic [BRP_W-1:0] prescaler_low_field,
   input wire logic [PRESCALER_EXTENSION_FIELD_W-1:0] prescaler_extension_field,
   input wire logic [SEG1_W-1:0] first_segment_field,
   input wire logic [SEG2_W-1:0] second_phase_field,
   input wire logic [SJW_W-1:0] jump_width_field,
   output logic tq_tick_r,
   output logic sample_point_r,
   output logic sampled_bit_r,
   output logic phase_error_r
);
   // Object store
   logic [ID_W-1:0] id_r [NUM_OBJ];
   logic [ID_W-1:0] mask_r [NUM_OBJ];
   logic [DLC_W-1:0] dlc_r [NUM_OBJ];
   logic [DATA_W-1:0] data_r [NUM_OBJ];
   logic [NUM_OBJ-1:0] xtd_r, xmask_r, dir_r, dmask_r, umask_r, valid_r, eob_r, rxie_r;
   logic [NUM_OBJ-1:0] new_data_r, lost_r, tx_request_flag_r, hit;
   logic [OBJ_W-1:0] rem_idx_r;
   logic rx_meta_r, rx_sync_r, last_ext_r;

   //////////////////////////////////////////////////////////////////////////
   // Acceptance filter per object; locked FIFO members drop out
   for (genvar g = 0; g < NUM_OBJ; g++) begin : g_acc
      wire [ID_W-1:0] m_full = umask_r[g] ? mask_r[g] : {ID_W{1'b1}};
      // Standard frames compare only the upper eleven bits
      wire [ID_W-1:0] m_eff = rx_extended ? m_full : {m_full[ID_W-1:STD_LSB], STD_LOW_ZERO};
      wire id_ok = ((id_r[g] ^ rx_identifier) & m_eff) == '0;
      wire xtd_ok = ~(umask_r[g] ? xmask_r[g] : 1'b1) | (xtd_r[g] == rx_extended);
      wire dir_ok = ~(umask_r[g] ? dmask_r[g] : 1'b1) | (dir_r[g] == rx_remote);
      wire free = eob_r[g] | ~new_data_r[g];
      assign hit[g] = valid_r[g] & id_ok & xtd_ok & dir_ok & free;
   end

   // Lowest-numbered match wins, giving FIFO fill order
   wire [OBJ_W-1:0] hit_idx = crx_first(hit);
   wire store = rx_frame_stb & ~rx_remote & (|hit);
   wire [ID_W-1:0] id_store = rx_extended ? rx_identifier
      : {rx_identifier[ID_W-1:STD_LSB], STD_LOW_ZERO};

   // Per-object selects for the flag updates
   wire [NUM_OBJ-1:0] cfg_sel = {NUM_OBJ{cfg_wr}} & crx_onehot(cfg_obj);
   wire [NUM_OBJ-1:0] rd_sel = {NUM_OBJ{rd_req}} & crx_onehot(rd_obj);
   wire [NUM_OBJ-1:0] nd_clr = rd_sel & {NUM_OBJ{clear_new_data_select}};
   wire [NUM_OBJ-1:0] ip_clr = rd_sel & {NUM_OBJ{clear_irq_pending_select}};
   wire [NUM_OBJ-1:0] st_sel = {NUM_OBJ{store}} & crx_onehot(hit_idx);
   wire [NUM_OBJ-1:0] sent_sel = {NUM_OBJ{rem_sent & rem_req_r}} & crx_onehot(rem_idx_r);

   // Software value replaces the flag, then hardware clears and sets
   wire [NUM_OBJ-1:0] nd_sw = (new_data_r & ~cfg_sel) | (cfg_sel & {NUM_OBJ{cfg_new_data_flag}});
   wire [NUM_OBJ-1:0] ip_sw = (irq_pending_flag_r & ~cfg_sel)
      | (cfg_sel & {NUM_OBJ{cfg_irq_pending_flag}});
   wire [NUM_OBJ-1:0] ml_sw = (lost_r & ~cfg_sel) | (cfg_sel & {NUM_OBJ{cfg_message_lost_flag}});
   wire [NUM_OBJ-1:0] tr_sw = (tx_request_flag_r & ~cfg_sel) | (cfg_sel & {NUM_OBJ{cfg_tx_request_flag}});
   // Store sets win over any clear in the same cycle
   wire [NUM_OBJ-1:0] new_data_nxt = (nd_sw & ~nd_clr) | st_sel;
   wire [NUM_OBJ-1:0] irq_nxt = (ip_sw & ~ip_clr) | (st_sel & rxie_r);
   wire [NUM_OBJ-1:0] lost_nxt = ml_sw | (st_sel & new_data_r);
   wire [NUM_OBJ-1:0] tx_request_flag_nxt = tr_sw & ~sent_sel & ~st_sel;

   // Remote request candidates: receive objects with a pending request
   wire [NUM_OBJ-1:0] rem_cand = tx_request_flag_r & valid_r & ~dir_r;
   wire [OBJ_W-1:0] rem_pick = crx_first(rem_cand);
   wire rem_drop = rem_sent | ~tx_request_flag_r[rem_idx_r];

   //////////////////////////////////////////////////////////////////////////
   // Bus pin synchroniser; idle level is recessive
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         rx_meta_r <= BUS_RECESSIVE;
         rx_sync_r <= BUS_RECESSIVE;
      end else begin
         rx_meta_r <= can_rx_pin;
         rx_sync_r <= rx_meta_r;
      end
   end

   // Object fields; a store after a same-cycle config write wins
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         for (int i = 0; i < NUM_OBJ; i++) begin
            id_r[i] <= '0;
            mask_r[i] <= '0;
            dlc_r[i] <= '0;
            data_r[i] <= '0;
         end
      end else begin
         if (cfg_wr) begin
            id_r[cfg_obj] <= cfg_identifier_bits;
            mask_r[cfg_obj] <= cfg_id_mask_bits;
            dlc_r[cfg_obj] <= cfg_length_code;
         end
         if (store) begin
            id_r[hit_idx] <= id_store;
            dlc_r[hit_idx] <= rx_length_code;
            data_r[hit_idx] <= rx_data;
         end
      end
   end

   // Static configuration bits, written only by software
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         {xtd_r, xmask_r, dir_r, dmask_r} <= '0;
         {umask_r, valid_r, eob_r, rxie_r} <= '0;
      end else begin
         xtd_r <= (xtd_r & ~cfg_sel) | (cfg_sel & {NUM_OBJ{cfg_extended_id_flag}});
         xmask_r <= (xmask_r & ~cfg_sel) | (cfg_sel & {NUM_OBJ{cfg_extended_flag_mask}});
         dir_r <= (dir_r & ~cfg_sel) | (cfg_sel & {NUM_OBJ{cfg_direction_bit}});
         dmask_r <= (dmask_r & ~cfg_sel) | (cfg_sel & {NUM_OBJ{cfg_direction_mask}});
         umask_r <= (umask_r & ~cfg_sel) | (cfg_sel & {NUM_OBJ{cfg_use_acceptance_mask}});
         valid_r <= (valid_r & ~cfg_sel) | (cfg_sel & {NUM_OBJ{cfg_object_valid_flag}});
         eob_r <= (eob_r & ~cfg_sel) | (cfg_sel & {NUM_OBJ{cfg_end_of_block_flag}});
         rxie_r <= (rxie_r & ~cfg_sel) | (cfg_sel & {NUM_OBJ{cfg_rx_irq_enable}});
      end
   end

   // Dynamic flags
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         new_data_r <= '0;
         irq_pending_flag_r <= '0;
         lost_r <= '0;
         tx_request_flag_r <= '0;
      end else begin
         new_data_r <= new_data_nxt;
         irq_pending_flag_r <= irq_nxt;
         lost_r <= lost_nxt;
         tx_request_flag_r <= tx_request_flag_nxt;
      end
   end

   // Store event report
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         rx_store_r <= 1'b0;
         rx_store_obj_r <= '0;
         last_ext_r <= 1'b0;
      end else begin
         rx_store_r <= store;
         if (store) rx_store_obj_r <= hit_idx;
         if (store) last_ext_r <= rx_extended;
      end
   end

   // Read of identifier, extended flag, length, data and status flags; buffer takes values from before clearing
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         buf_valid_r <= 1'b0;
         buf_obj_r <= '0;
         buf_identifier_bits_r <= '0;
         buf_extended_id_flag_r <= 1'b0;
         buf_length_code_r <= '0;
         buf_data_r <= '0;
         {buf_new_data_flag_r, buf_message_lost_flag_r} <= 2'h0;
         {buf_irq_pending_flag_r, buf_tx_request_flag_r} <= 2'h0;
      end else begin
         buf_valid_r <= rd_req;
         if (rd_req) begin
            buf_obj_r <= rd_obj;
            buf_identifier_bits_r <= id_r[rd_obj];
            buf_extended_id_flag_r <= xtd_r[rd_obj];
            buf_length_code_r <= dlc_r[rd_obj];
            buf_data_r <= data_r[rd_obj];
            buf_new_data_flag_r <= new_data_r[rd_obj];
            buf_message_lost_flag_r <= lost_r[rd_obj];
            buf_irq_pending_flag_r <= irq_pending_flag_r[rd_obj];
            buf_tx_request_flag_r <= tx_request_flag_r[rd_obj];
         end
      end
   end

   // Remote request holder; withdrawn if a data frame arrives first
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         rem_req_r <= 1'b0;
         rem_idx_r <= '0;
         rem_identifier_r <= '0;
         rem_extended_r <= 1'b0;
      end else if (rem_req_r) begin
         if (rem_drop) rem_req_r <= 1'b0;
      end else if (|rem_cand) begin
         rem_req_r <= 1'b1;
         rem_idx_r <= rem_pick;
         rem_identifier_r <= id_r[rem_pick];
         rem_extended_r <= xtd_r[rem_pick];
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Quantum prescaler and segment sequencer
   crx_bit_timing u_bit_timing (
      .clk_sys(clk_sys),
      .reset(reset),
      .prescaler_low_field(prescaler_low_field),
      .prescaler_extension_field(prescaler_extension_field),
      .first_segment_field(first_segment_field),
      .second_phase_field(second_phase_field),
      .jump_width_field(jump_width_field),
      .rx_bit(rx_sync_r),
      .tq_tick_r(tq_tick_r),
      .sample_point_r(sample_point_r),
      .sampled_bit_r(sampled_bit_r),
      .phase_error_r(phase_error_r)
   );

   //////////////////////////////////////////////////////////////////////////
   // Helpers for the checks below
   wire rd_nd_now = new_data_r[rd_obj];
   wire [ID_W-1:0] chk_m = umask_r[hit_idx] ? mask_r[hit_idx] : {ID_W{1'b1}};

   std_low_zero_a: assert property (@(posedge clk_sys) disable iff (reset)
      (rx_store_r && !last_ext_r) |-> (id_r[rx_store_obj_r][STD_LSB-1:0] == STD_LOW_ZERO))
      else $error("standard frame stored with nonzero low identifier");

   irq_on_store_a: assert property (@(posedge clk_sys) disable iff (reset)
      (rx_store_r && rxie_r[rx_store_obj_r]) |-> irq_pending_flag_r[rx_store_obj_r])
      else $error("pending flag not set on store");

   store_payload_a: assert property (@(posedge clk_sys) disable iff (reset)
      rx_store_r |-> (dlc_r[rx_store_obj_r] == $past(rx_length_code))
         && (data_r[rx_store_obj_r] == $past(rx_data)) && new_data_r[rx_store_obj_r])
      else $error("stored length or data wrong");

   mask_match_a: assert property (@(posedge clk_sys) disable iff (reset)
      store |-> (((id_r[hit_idx][ID_W-1:STD_LSB] ^ rx_identifier[ID_W-1:STD_LSB])
         & chk_m[ID_W-1:STD_LSB]) == '0))
      else $error("accepted identifier mismatches under mask");

   buf_old_flag_a: assert property (@(posedge clk_sys) disable iff (reset)
      rd_req |=> (buf_new_data_flag_r == $past(rd_nd_now)) && buf_valid_r)
      else $error("buffer did not get pre-clear flag");

   ram_cleared_a: assert property (@(posedge clk_sys) disable iff (reset)
      (rd_req && clear_new_data_select && !rx_frame_stb && !cfg_wr)
         |=> !new_data_r[buf_obj_r])
      else $error("new data flag not cleared in store");

   lost_sticky_a: assert property (@(posedge clk_sys) disable iff (reset)
      !cfg_wr |=> ((lost_r & $past(lost_r)) == $past(lost_r)))
      else $error("message lost flag cleared by hardware");

   fifo_lock_a: assert property (@(posedge clk_sys) disable iff (reset)
      store |-> (eob_r[hit_idx] || !new_data_r[hit_idx]))
      else $error("locked FIFO member written");

   tx_request_flag_cancel_a: assert property (@(posedge clk_sys) disable iff (reset)
      rx_store_r |-> !tx_request_flag_r[rx_store_obj_r] ##1 !(rem_req_r && rem_idx_r == $past(rx_store_obj_r)))
      else $error("remote request survived matching data frame");

   remote_id_a: assert property (@(posedge clk_sys) disable iff (reset)
      ($rose(rem_req_r) && !rx_store_r) |-> (rem_identifier_r == id_r[rem_idx_r]))
      else $error("remote frame identifier differs from object");
endmodule : crx_rx_handler

// ### rtl/crx_pkg.sv
/*
 Shared constants, state type and helper functions for the receive object
 handler and its bit timing prescaler.
 Assumes one system clock domain; object numbers are 0-based indices.
*/
package crx_pkg;
   // Object store geometry
   localparam int NUM_OBJ = 32;
   localparam int OBJ_W = 5;
   localparam int ID_W = 29;
   localparam int STD_LSB = 18;
   localparam int DLC_W = 4;
   localparam int DATA_W = 64;
   localparam logic [STD_LSB-1:0] STD_LOW_ZERO = 18'h00000;

   // Bit timing field widths
   localparam int BRP_W = 6;
   localparam int PRESCALER_EXTENSION_FIELD_W = 4;
   localparam int SEG1_W = 4;
   localparam int SEG2_W = 3;
   localparam int SJW_W = 2;
   localparam int TQ_W = 10;
   localparam int SEG_W = 5;
   localparam logic [TQ_W-1:0] PRE_EXT_MUL = 10'h040;
   localparam logic [SEG_W-1:0] SEG_ONE = 5'h01;
   localparam logic BUS_RECESSIVE = 1'b1;

   // Bit time segments
   typedef enum logic [2:0] {
      BT_SYNC = 3'h1,
      BT_SEG1 = 3'h2,
      BT_SEG2 = 3'h4
   } crx_bt_state_t;

   // One-hot select of an object
   function automatic logic [NUM_OBJ-1:0] crx_onehot(input logic [OBJ_W-1:0] i);
      return {{(NUM_OBJ-1){1'b0}}, 1'b1} << i;
   endfunction : crx_onehot

   // Lowest set index, zero when none
   function automatic logic [OBJ_W-1:0] crx_first(input logic [NUM_OBJ-1:0] v);
      logic [OBJ_W-1:0] idx;
      idx = '0;
      for (int i = NUM_OBJ - 1; i >= 0; i--) begin
         if (v[i]) idx = OBJ_W'(i);
      end
      return idx;
   endfunction : crx_first
endpackage : crx_pkg

// ### rtl/crx_bit_timing.sv
/*
 Time quantum prescaler and bit segment sequencer with resynchronisation.
 Assumes rx_bit is already synchronised to clk_sys and fields are static
 while the bus is active.
*/
`timescale 1ns/1ps
module crx_bit_timing import crx_pkg::*; (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic reset,
   // Timing configuration, each programmed as quantity minus one
   input wire logic [BRP_W-1:0] prescaler_low_field,
   input wire logic [PRESCALER_EXTENSION_FIELD_W-1:0] prescaler_extension_field,
   input wire logic [SEG1_W-1:0] first_segment_field,
   input wire logic [SEG2_W-1:0] second_phase_field,
   input wire logic [SJW_W-1:0] jump_width_field,
   // Bus level and timing events
   input wire logic rx_bit,
   output logic tq_tick_r,
   output logic sample_point_r,
   output logic sampled_bit_r,
   output logic phase_error_r
);
   crx_bt_state_t state_r, state_nxt;
   logic [TQ_W-1:0] pre_cnt_r;
   logic [SEG_W-1:0] seg_cnt_r, seg_cnt_nxt, seg1_len_r, seg1_len_nxt, seg2_len_r, seg2_len_nxt;
   logic rx_last_r, done_r, done_nxt, sample_nxt, perr_nxt;

   // Quantum is (ext*0x40 + low + 1) system clocks
   wire [TQ_W-1:0] pre_top = TQ_W'(TQ_W'(prescaler_extension_field) * PRE_EXT_MUL)
      + TQ_W'(prescaler_low_field);
   wire tq_now = (pre_cnt_r == pre_top);
   wire [SEG_W-1:0] seg1_base = SEG_W'(first_segment_field) + SEG_ONE;
   wire [SEG_W-1:0] seg2_base = SEG_W'(second_phase_field) + SEG_ONE;
   wire [SEG_W-1:0] sjw_q = SEG_W'(jump_width_field) + SEG_ONE;
   wire [SEG_W-1:0] cnt_inc = seg_cnt_r + SEG_ONE;
   wire [SEG_W-1:0] ext = (cnt_inc < sjw_q) ? cnt_inc : sjw_q;
   wire [SEG_W-1:0] remain = seg2_len_r - seg_cnt_r;
   wire [SEG_W-1:0] s2_short = seg2_len_r - sjw_q;
   // Falling edge outside sync is a phase error; one resync per bit
   wire resync = tq_now & rx_last_r & ~rx_bit & ~done_r & (state_r != BT_SYNC);

   //////////////////////////////////////////////////////////////////////////
   // Segment sequencing, only on quantum ticks
   always_comb begin
      state_nxt = state_r;
      seg_cnt_nxt = seg_cnt_r;
      seg1_len_nxt = seg1_len_r;
      seg2_len_nxt = seg2_len_r;
      done_nxt = done_r;
      sample_nxt = 1'b0;
      perr_nxt = resync;
      if (tq_now) begin
         case (state_r)
            BT_SYNC: begin
               state_nxt = BT_SEG1;
               seg_cnt_nxt = '0;
               seg1_len_nxt = seg1_base;
               seg2_len_nxt = seg2_base;
               done_nxt = 1'b0;
            end
            BT_SEG1: begin
               if (resync) begin
                  seg1_len_nxt = seg1_len_r + ext;
                  seg_cnt_nxt = cnt_inc;
                  done_nxt = 1'b1;
               end else if (cnt_inc >= seg1_len_r) begin
                  state_nxt = BT_SEG2;
                  seg_cnt_nxt = '0;
                  sample_nxt = 1'b1;
               end else begin
                  seg_cnt_nxt = cnt_inc;
               end
            end
            BT_SEG2: begin
               if (resync && remain <= sjw_q) begin
                  // Edge quantum serves as the next sync segment
                  state_nxt = BT_SEG1;
                  seg_cnt_nxt = '0;
                  seg1_len_nxt = seg1_base;
                  seg2_len_nxt = seg2_base;
                  done_nxt = 1'b0;
               end else if (resync) begin
                  seg2_len_nxt = s2_short;
                  done_nxt = 1'b1;
                  seg_cnt_nxt = cnt_inc;
                  if (cnt_inc >= s2_short) state_nxt = BT_SYNC;
               end else if (cnt_inc >= seg2_len_r) begin
                  state_nxt = BT_SYNC;
               end else begin
                  seg_cnt_nxt = cnt_inc;
               end
            end
            default: state_nxt = BT_SYNC;
         endcase
      end
   end

   // Sequencer registers
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         state_r <= BT_SYNC;
         seg_cnt_r <= '0;
         seg1_len_r <= SEG_ONE;
         seg2_len_r <= SEG_ONE;
         done_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         seg_cnt_r <= seg_cnt_nxt;
         seg1_len_r <= seg1_len_nxt;
         seg2_len_r <= seg2_len_nxt;
         done_r <= done_nxt;
      end
   end

   // Prescaler and event outputs
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         pre_cnt_r <= '0;
         rx_last_r <= BUS_RECESSIVE;
         tq_tick_r <= 1'b0;
         sample_point_r <= 1'b0;
         sampled_bit_r <= BUS_RECESSIVE;
         phase_error_r <= 1'b0;
      end else begin
         pre_cnt_r <= tq_now ? '0 : pre_cnt_r + TQ_W'(1);
         if (tq_now) rx_last_r <= rx_bit;
         tq_tick_r <= tq_now;
         sample_point_r <= sample_nxt;
         if (sample_nxt) sampled_bit_r <= rx_bit;
         phase_error_r <= perr_nxt;
      end
   end

   // Lengthened first segment never exceeds base plus jump width
   seg1_bound_a: assert property (@(posedge clk_sys) disable iff (reset)
      (state_r == BT_SEG1) |-> (seg1_len_r <= seg1_base + sjw_q))
      else $error("first segment lengthened beyond jump width");

   // Ticks spaced by the programmed prescale
   tq_period_a: assert property (@(posedge clk_sys) disable iff (reset)
      (tq_now && $stable(pre_top)) |=> (pre_cnt_r == '0) ##1 (pre_cnt_r == TQ_W'(pre_top != '0)))
      else $error("quantum prescaler period wrong");
endmodule : crx_bit_timing

// ### sim/crx_peer_node.sv
/* Far node model: answers remote requests, bus dominant only while answering.
 Assumes rem_req_r comes from the node under test on clk_sys. */
`timescale 1ns/1ps
module crx_peer_node (
   // Clock and answer delay select
   input wire logic clk_sys,
   input wire logic slow,
   // Remote handshake and bus pin
   input wire logic rem_req_r,
   output logic rem_sent,
   output logic can_rx_pin
);
   int wait_n = 0, dom_n = 0;
   ////////////////////////////////////////
   // Idle bus, no answer pending
   initial {rem_sent, can_rx_pin} = 2'h1;
   // Pulse only while a request stands; slow leaves room for a data frame first
   always @(negedge clk_sys) begin
      rem_sent <= rem_req_r && !rem_sent && wait_n == (slow ? 20 : 2);
      wait_n <= rem_req_r ? wait_n + 1 : 0;
      // Answering frame pulls the bus dominant for about three bits
      dom_n <= rem_sent ? 40 : (dom_n > 0 ? dom_n - 1 : 0);
      can_rx_pin <= !rem_sent && dom_n == 0;
   end
endmodule : crx_peer_node

// ### sim/tb_top.sv
/* Bench for the receive object handler: objects, FIFO, remote, timing.
 Assumes the peer model drives the bus pin and remote answers. */
`timescale 1ns/1ps
module tb_top import crx_pkg::*;;
   logic clk_sys = 0, reset = 1, cfg_wr = 0, rd_req = 0, rx_frame_stb = 0, slow = 1;
   logic cfg_use_acceptance_mask = 0, cfg_end_of_block_flag = 0, cfg_tx_request_flag = 0;
   logic cfg_rx_irq_enable = 0, cfg_extended_id_flag = 0, cfg_extended_flag_mask = 0;
   logic cfg_direction_bit = 0, cfg_direction_mask = 0, cfg_object_valid_flag = 1;
   logic cfg_new_data_flag = 0, cfg_message_lost_flag = 0, cfg_irq_pending_flag = 0;
   logic rx_extended = 0, rx_remote = 0, clear_new_data_select = 0, clear_irq_pending_select = 0;
   logic can_rx_pin, rem_sent, rem_req_r, rem_extended_r, sampled_bit_r, phase_error_r;
   logic [OBJ_W-1:0] cfg_obj = 0, rd_obj = 0, buf_obj_r, rx_store_obj_r;
   logic [ID_W-1:0] cfg_identifier_bits = 0, cfg_id_mask_bits = 0, rx_identifier = 0;
   logic [ID_W-1:0] buf_identifier_bits_r, rem_identifier_r;
   logic [DLC_W-1:0] cfg_length_code = 4'h8, rx_length_code = 4'h8, buf_length_code_r;
   logic [DATA_W-1:0] rx_data = 0, buf_data_r;
   logic buf_valid_r, buf_extended_id_flag_r, buf_new_data_flag_r, buf_message_lost_flag_r;
   logic buf_irq_pending_flag_r, buf_tx_request_flag_r, rx_store_r, tq_tick_r, sample_point_r;
   logic [NUM_OBJ-1:0] irq_pending_flag_r;
   logic [BRP_W-1:0] prescaler_low_field = 6'h02;
   logic [PRESCALER_EXTENSION_FIELD_W-1:0] prescaler_extension_field = 4'h0;
   logic [SEG1_W-1:0] first_segment_field = 4'h1;
   logic [SEG2_W-1:0] second_phase_field = 3'h1;
   logic [SJW_W-1:0] jump_width_field = 2'h0;
   int n_errors = 0, n_checks = 0, cyc = 0, n_pe = 0, n_dom = 0;
   crx_rx_handler crx_rx_handler_i (.*);
   crx_peer_node crx_peer_node_i (.*);
   ////////////////////////////////////////
   // Clock, and a guard far above the under two hundred cycles needed
   always #20 clk_sys = ~clk_sys;
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 3000) begin
         n_errors++;
         give_verdict();
      end
   end
   // Phase errors and dominant samples seen on the link
   always @(negedge clk_sys) begin
      n_pe += phase_error_r;
      n_dom += !sampled_bit_r;
   end
   task automatic give_verdict();
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : give_verdict
   task automatic chk(input logic [63:0] s, e);
      n_checks++;
      if (s !== e) begin
         n_errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask : chk
   // Object write, frame arrival and read transfer, each driven at the falling edge
   task automatic cfg(input logic [4:0] o, input logic [10:0] id, mk, input logic u, e, t);
      @(negedge clk_sys);
      {cfg_wr, cfg_obj, cfg_use_acceptance_mask, cfg_end_of_block_flag} = {1'h1, o, u, e};
      {cfg_tx_request_flag, cfg_rx_irq_enable} = {t, !t};
      {cfg_identifier_bits, cfg_id_mask_bits} = {id, 18'h0, mk, 18'h0};
      @(negedge clk_sys);
      cfg_wr = 0;
   endtask : cfg
   task automatic frm(input logic [10:0] id, input logic s, input logic [4:0] eo);
      @(negedge clk_sys);
      {rx_frame_stb, rx_identifier} = {1'h1, id, 18'h2A5A5};
      rx_data = {2{3'h0, rx_identifier}};
      @(negedge clk_sys);
      rx_frame_stb = 0;
      chk({rx_store_r, s ? rx_store_obj_r : 5'h0}, {s, eo});
   endtask : frm
   task automatic rdo(input logic [4:0] o, input logic c);
      @(negedge clk_sys);
      {rd_req, rd_obj, clear_new_data_select, clear_irq_pending_select} = {1'h1, o, c, c};
      @(negedge clk_sys);
      rd_req = 0;
      chk({buf_valid_r, buf_obj_r}, {1'h1, o});
   endtask : rdo
   // Clocks from one pulse to the next of a tick or a sample point
   task automatic gap(input logic w, input int e);
      int n = 0;
      while ((w ? sample_point_r : tq_tick_r) !== 1'h1) @(negedge clk_sys);
      while (n == 0 || (w ? sample_point_r : tq_tick_r) !== 1'h1) begin
         @(negedge clk_sys);
         n++;
      end
      chk(n, e);
   endtask : gap
   ////////////////////////////////////////
   initial begin
      repeat (10) @(negedge clk_sys);
      reset = 0;
      chk({irq_pending_flag_r, rem_req_r}, 0);
      $display("reset done");
      // Single object: store, clearing read, overrun
      cfg(0, 11'h123, 0, 0, 1, 0);
      frm(11'h123, 1, 0);
      rdo(0, 1);
      chk(buf_identifier_bits_r, {11'h123, 18'h0});
      chk(buf_data_r, {2{3'h0, 11'h123, 18'h2A5A5}});
      chk({buf_length_code_r, buf_new_data_flag_r, buf_irq_pending_flag_r}, 6'h23);
      chk({buf_extended_id_flag_r, buf_tx_request_flag_r}, 0);
      rdo(0, 0);
      chk({buf_new_data_flag_r, buf_irq_pending_flag_r, irq_pending_flag_r[0]}, 0);
      frm(11'h123, 1, 0);
      frm(11'h123, 1, 0);
      rdo(0, 1);
      rdo(0, 1);
      chk({buf_new_data_flag_r, buf_message_lost_flag_r}, 2'h1);
      $display("object done");
      // Masked group, then a two-member FIFO
      cfg(3, 11'h2F0, 11'h7F0, 1, 1, 0);
      frm(11'h2F5, 1, 3);
      frm(11'h3F5, 0, 0);
      // Extended frame: refused where the flag is compared, taken where masked off
      rx_extended = 1;
      frm(11'h123, 0, 0);
      frm(11'h2F5, 1, 3);
      rx_extended = 0;
      cfg(4, 11'h555, 0, 0, 0, 0);
      cfg(5, 11'h555, 0, 0, 1, 0);
      frm(11'h555, 1, 4);
      frm(11'h555, 1, 5);
      frm(11'h555, 1, 5);
      rdo(4, 1);
      frm(11'h555, 1, 4);
      $display("filter done");
      // Remote request beaten by data, then answered promptly
      cfg(7, 11'h6A0, 0, 0, 1, 1);
      @(negedge clk_sys);
      chk({rem_req_r, rem_extended_r, rem_identifier_r}, {2'h2, 11'h6A0, 18'h0});
      frm(11'h6A0, 1, 7);
      @(negedge clk_sys);
      chk(rem_req_r, 0);
      slow = 0;
      cfg(7, 11'h6A0, 0, 0, 1, 1);
      repeat (8) @(negedge clk_sys);
      chk(rem_req_r, 0);
      // Answer drives the bus dominant once: one resync, then recessive again
      repeat (60) @(negedge clk_sys);
      chk(n_pe, 1);
      chk({n_dom != 0, sampled_bit_r}, 2'h3);
      $display("remote done");
      gap(0, 3);
      gap(1, 15);
      $display("timing done");
      give_verdict();
   end
endmodule : tb_top
